// >>> rtl/reset_ctrl_pkg.sv
/*
 * constants, types and state record for the reset controller with watchdog.
 * assumes one 100 MHz system clock, static fuse inputs and a watchdog
 * oscillator tick that arrives asynchronously on a pin.
 */
// Functional notes
// - any reset returns I/O registers to initial values, then restart at reset vector.
// - port reset asserts asynchronously as soon as any source asserts; here only power-on, pin and test-port do, watchdog and brown-out on the clock.
// - after all sources release, internal reset stretches for the fuse-chosen delay.
// - internal reset combines power-on, pin, watchdog, brown-out and test-port sources.
// - pin low beyond minimum pulse width resets, even without a clock; here the width filter runs on the system clock, only port reset needs none.
// - power-on asserts reset at once; its release starts the delay counter.
// - watchdog resets only when enabled and period expires without restart.
// - enabled brown-out asserts reset at once; recovery releases through the delay.
// - reset held while the test-port reset register holds one.
// - brown-out acts only if under-voltage persists beyond a minimum duration.
// - watchdog expiry gives one-cycle pulse; delay starts at its falling edge.
// - brown-out level fuse picks low level unprogrammed, high level programmed.
// - bandgap enabled only by brown-out enable, comparator select or converter.
// - watchdog counts ticks of its own one megahertz oscillator.
// - watchdog counter clears on restart, on disable and on chip reset.
// - eight prescaled timeouts; expiry resets the chip.
// - level 1: starts disabled, disable and timeout change need timed sequence.
// - always-on fuse gives level 2: enabled from reset, never disabled.
// - compat fuse alone gives level 0: disable timed, timeout change free.
// - enabling the watchdog is always a plain write.
// - writing change-enable and enable together opens a four-cycle window.
// - prescale select gives 16K to 2048K oscillator cycles, doubling per step.
// - in level 2 enable reads one and cannot be cleared.
package reset_ctrl_pkg;

	// ----------------------------------------
	// register map and fields
	// ----------------------------------------
	localparam logic [7:0] WDT_CTRL_ADDR = 8'h00;
	localparam logic [7:0] STATUS_ADDR = 8'h01;
	localparam int CE_BIT = 4;
	localparam int EN_BIT = 3;
	localparam int PS_LSB = 0;
	localparam logic [2:0] PS_RESET = 3'h0;
	localparam logic [7:0] RDATA_ZERO = 8'h00;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int EXT_MIN_PULSE_NS = 1500;
	localparam int BOD_MIN_NS = 2000;
	localparam int EXT_MIN_CYCLES = (EXT_MIN_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int BOD_MIN_CYCLES = (BOD_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0] EXT_LIMIT = 8'(EXT_MIN_CYCLES);
	localparam logic [7:0] BOD_LIMIT = 8'(BOD_MIN_CYCLES);
	localparam logic [2:0] CE_WINDOW = 3'h4;
	localparam int WDT_BASE_DEFAULT = 16384;
	localparam int DELAY_W = 20;
	localparam int WDT_W = 22;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [2:0] {
		LEVEL0 = 3'b001,
		LEVEL1 = 3'b010,
		LEVEL2 = 3'b100
	} safety_level_t;

	typedef struct packed {
		logic change_enable;
		logic enable;
		logic [2:0] prescale;
	} wdt_ctrl_t;

	typedef struct packed {
		logic [1:0] por_sync;
		logic [1:0] ext_n_sync;
		logic [1:0] bod_sync;
		logic [1:0] test_sync;
		logic [1:0] osc_sync;
		logic osc_prev;
		logic [7:0] ext_cnt;
		logic [7:0] bod_cnt;
		logic ext_active;
		logic bod_active;
		logic hold;
		logic [DELAY_W-1:0] delay_cnt;
		wdt_ctrl_t ctrl;
		logic [2:0] ce_cnt;
		logic [WDT_W-1:0] wdt_cnt;
		logic wdt_pulse;
		safety_level_t level;
		logic bandgap;
		logic level_high;
		logic [7:0] rdata;
	} ctrl_state_t;

endpackage

// >>> rtl/reset_control_with_watchdog.sv
/*
 * reset controller: gathers five reset sources, stretches the internal reset,
 * holds the watchdog and its safety levels, and gates the bandgap reference.
 * assumes fuses and the delay length are static, the restart strobe comes from
 * the core on the system clock, and the oscillator tick is asynchronous.
 */
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module reset_control_with_watchdog #(
	parameter int WDT_BASE_CYCLES = reset_ctrl_pkg::WDT_BASE_DEFAULT
) (
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	input wire logic power_on_reset_in,
	input wire logic ext_reset_n_in,
	input wire logic brownout_raw_in,
	input wire logic test_reset_reg_in,
	input wire logic watchdog_osc_in,
	input wire logic brownout_enable_fuse_in,
	input wire logic brownout_level_fuse_in,
	input wire logic compat_mode_fuse_in,
	input wire logic watchdog_always_on_fuse_in,
	input wire logic comparator_bandgap_select_in,
	input wire logic adc_enable_in,
	input wire logic [reset_ctrl_pkg::DELAY_W-1:0] startup_timeout_in,
	input wire logic watchdog_restart_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic write_in,
	input wire logic read_in,
	output logic [7:0] rdata_out,
	output logic port_reset_out,
	output logic internal_reset_out,
	output logic watchdog_reset_out,
	output logic bandgap_enable_out,
	output logic brownout_level_high_out
);
	import reset_ctrl_pkg::*;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic safety_level_t level_of(input logic compat, input logic always_on);
		if (always_on) begin
			return LEVEL2;
		end else if (compat) begin
			return LEVEL0;
		end
		return LEVEL1;
	endfunction

	function automatic logic [WDT_W-1:0] wdt_limit(input logic [2:0] ps);
		return WDT_W'(WDT_BASE_CYCLES) << ps;
	endfunction

	function automatic wdt_ctrl_t ctrl_initial(input safety_level_t lvl);
		wdt_ctrl_t c;
		c.change_enable = 1'b0;
		c.enable = (lvl == LEVEL2);
		c.prescale = PS_RESET;
		return c;
	endfunction

	ctrl_state_t st_reg;
	ctrl_state_t st_next;
	logic port_hold_reg;
	logic async_src;

	// ----------------------------------------
	// asynchronous port reset
	// ----------------------------------------
	// needs no clock to assert; only released by the clocked internal reset
	assign async_src = power_on_reset_in | ~ext_reset_n_in | test_reset_reg_in;

	always_ff @(posedge clk_sys_in or posedge async_src) begin
		if (async_src) begin
			port_hold_reg <= 1'b1;
		end else begin
			// follow the synchronous reset too, so ports never lag internal reset
			port_hold_reg <= st_next.hold | ~rstn_in;
		end
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic any_src;
		logic ext_low;
		logic bod_low;
		logic tick;
		logic ce_ok;
		wdt_ctrl_t w;
		any_src = 1'b0;
		ext_low = 1'b0;
		bod_low = 1'b0;
		tick = 1'b0;
		ce_ok = 1'b0;
		w = wdt_ctrl_t'(wdata_in[4:0]);
		st_next = st_reg;

		st_next.por_sync = {st_reg.por_sync[0], power_on_reset_in};
		st_next.ext_n_sync = {st_reg.ext_n_sync[0], ext_reset_n_in};
		st_next.bod_sync = {st_reg.bod_sync[0], brownout_raw_in};
		st_next.test_sync = {st_reg.test_sync[0], test_reset_reg_in};
		st_next.osc_sync = {st_reg.osc_sync[0], watchdog_osc_in};
		st_next.osc_prev = st_reg.osc_sync[1];
		st_next.level = level_of(compat_mode_fuse_in, watchdog_always_on_fuse_in);
		st_next.level_high = brownout_level_fuse_in;
		st_next.bandgap = brownout_enable_fuse_in | comparator_bandgap_select_in
			| adc_enable_in;

		// pin filter: short pulses are ignored
		ext_low = ~st_reg.ext_n_sync[1];
		if (!ext_low) begin
			st_next.ext_cnt = '0;
			st_next.ext_active = 1'b0;
		end else if (st_reg.ext_cnt != EXT_LIMIT) begin
			st_next.ext_cnt = st_reg.ext_cnt + 8'h01;
		end else begin
			st_next.ext_active = 1'b1;
		end

		// brown-out qualification, then held until the supply recovers
		bod_low = st_reg.bod_sync[1] & brownout_enable_fuse_in;
		if (!bod_low) begin
			st_next.bod_cnt = '0;
			st_next.bod_active = 1'b0;
		end else if (st_reg.bod_cnt != BOD_LIMIT) begin
			st_next.bod_cnt = st_reg.bod_cnt + 8'h01;
		end else begin
			st_next.bod_active = 1'b1;
		end

		// five sources into one, stretched by the delay counter
		any_src = st_reg.por_sync[1] | st_reg.ext_active | st_reg.wdt_pulse
			| st_reg.bod_active | st_reg.test_sync[1];
		if (any_src) begin
			st_next.hold = 1'b1;
			st_next.delay_cnt = startup_timeout_in;
		end else if (st_reg.delay_cnt != '0) begin
			st_next.delay_cnt = st_reg.delay_cnt - DELAY_W'(1);
		end else begin
			st_next.hold = 1'b0;
		end

		// change-enable window
		if (st_reg.ce_cnt != '0) begin
			st_next.ce_cnt = st_reg.ce_cnt - 3'h1;
		end
		ce_ok = st_reg.ctrl.change_enable;
		if (write_in && addr_in == WDT_CTRL_ADDR) begin
			if (w.change_enable && w.enable) begin
				st_next.ce_cnt = CE_WINDOW;
			end
			if (w.enable) begin
				st_next.ctrl.enable = 1'b1;
			end else if (ce_ok && st_reg.level != LEVEL2) begin
				st_next.ctrl.enable = 1'b0;
			end
			unique case (st_reg.level)
				LEVEL0: st_next.ctrl.prescale = w.prescale;
				LEVEL1, LEVEL2: begin
					if (ce_ok) begin
						st_next.ctrl.prescale = w.prescale;
					end
				end
			endcase
		end
		st_next.ctrl.change_enable = (st_next.ce_cnt != '0);
		if (st_reg.level == LEVEL2) begin
			st_next.ctrl.enable = 1'b1;
		end

		// watchdog counter on the oscillator tick
		tick = st_reg.osc_sync[1] & ~st_reg.osc_prev;
		st_next.wdt_pulse = 1'b0;
		if (watchdog_restart_in || !st_reg.ctrl.enable || st_reg.hold) begin
			st_next.wdt_cnt = '0;
		end else if (tick) begin
			if (st_reg.wdt_cnt == wdt_limit(st_reg.ctrl.prescale) - WDT_W'(1)) begin
				st_next.wdt_cnt = '0;
				st_next.wdt_pulse = 1'b1;
			end else begin
				st_next.wdt_cnt = st_reg.wdt_cnt + WDT_W'(1);
			end
		end

		// chip reset puts the control register back to its initial value
		if (st_reg.hold) begin
			st_next.ctrl = ctrl_initial(st_reg.level);
			st_next.ce_cnt = '0;
		end

		st_next.rdata = RDATA_ZERO;
		if (read_in) begin
			if (addr_in == WDT_CTRL_ADDR) begin
				st_next.rdata = {3'h0, st_reg.ctrl};
			end else if (addr_in == STATUS_ADDR) begin
				st_next.rdata = {4'h0, st_reg.level, st_reg.hold};
			end
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	// power-on synchroniser and hold reset asserted, pin synchroniser idle-high, so reset persists past release
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			st_reg <= '0;
			st_reg.por_sync <= 2'b11;
			st_reg.ext_n_sync <= 2'b11;
			st_reg.hold <= 1'b1;
			st_reg.level <= LEVEL1;
			st_reg.ctrl <= ctrl_initial(LEVEL1);
		end else begin
			st_reg <= st_next;
		end
	end

	assign rdata_out = st_reg.rdata;
	assign port_reset_out = port_hold_reg;
	assign internal_reset_out = st_reg.hold;
	assign watchdog_reset_out = st_reg.wdt_pulse;
	assign bandgap_enable_out = st_reg.bandgap;
	assign brownout_level_high_out = st_reg.level_high;

endmodule

// >>> verif/rst_monitor.sv
/* checker: port relations of the reset block.
   assumes a bind onto the top module, one clock domain. */
`timescale 1ns/1ps
module rst_monitor #(parameter int WDT_BASE_CYCLES = 4) (
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	input wire logic power_on_reset_in,
	input wire logic ext_reset_n_in,
	input wire logic test_reset_reg_in,
	input wire logic brownout_enable_fuse_in,
	input wire logic comparator_bandgap_select_in,
	input wire logic adc_enable_in,
	input wire logic port_reset_out,
	input wire logic internal_reset_out,
	input wire logic watchdog_reset_out,
	input wire logic bandgap_enable_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rstn_in);
	// ----------------
	// checks
	// ----------------
	a_bg_gate: assert property ($past(rstn_in) |-> bandgap_enable_out ==
		$past(brownout_enable_fuse_in | comparator_bandgap_select_in | adc_enable_in))
		else $error("bandgap enable wrong");
	a_wdt_single: assert property (watchdog_reset_out |=> !watchdog_reset_out)
		else $error("watchdog pulse too long");
	a_wdt_resets: assert property (watchdog_reset_out |=> internal_reset_out)
		else $error("watchdog pulse gave no reset");
	a_port_async: assert property ((power_on_reset_in || !ext_reset_n_in ||
		test_reset_reg_in) |-> port_reset_out) else $error("ports not held");
	a_port_follow: assert property (internal_reset_out |-> port_reset_out)
		else $error("ports free in reset");
	a_por_fast: assert property ($rose(power_on_reset_in) |->
		##[1:4] internal_reset_out) else $error("power-on reset late");
	a_test_hold: assert property (test_reset_reg_in [*4] |-> internal_reset_out)
		else $error("test reset not held");
	a_clean_rel: assert property ($fell(internal_reset_out) |->
		!power_on_reset_in && ext_reset_n_in && !test_reset_reg_in)
		else $error("release with source active");
	c_wdt: cover property (watchdog_reset_out);
	c_rel: cover property ($fell(internal_reset_out));
	c_pin: cover property (!ext_reset_n_in && port_reset_out);
endmodule

bind reset_control_with_watchdog rst_monitor #(.WDT_BASE_CYCLES(WDT_BASE_CYCLES)) u_mon (.*);

// >>> verif/supply_model.sv
/* partner: supply monitors, reset pin, test register, watchdog oscillator.
   assumes the bench calls hit() from its own thread. */
`timescale 1ns/1ps
module supply_model (
	input wire logic clk_in,
	output logic por_out,
	output logic ext_n_out,
	output logic bod_out,
	output logic test_out,
	output logic osc_out
);
	// pin has a pull-up, so idle is high
	initial begin
		{por_out, bod_out, test_out, osc_out} = 4'h0;
		ext_n_out = 1'b1;
	end
	always #500 osc_out = ~osc_out; // free-running, 1 MHz
	task automatic hit(input int src, input int cyc);
		@(posedge clk_in);
		case (src)
			0: por_out <= 1'b1;
			1: ext_n_out <= 1'b0;
			2: bod_out <= 1'b1;
			default: test_out <= 1'b1;
		endcase
		repeat (cyc) @(posedge clk_in);
		{por_out, bod_out, test_out} <= 3'h0;
		ext_n_out <= 1'b1;
	endtask
endmodule

// >>> verif/testbench.sv
/* testbench: safety levels, change window, watchdog, reset sources, bandgap.
   assumes the monitor is bound and the partner drives the supply pins. */
`timescale 1ns/1ps
module testbench;
	import reset_ctrl_pkg::*;
	logic clk_sys_in = 1'b0, rstn_in = 1'b0, watchdog_restart_in = 1'b0;
	logic brownout_enable_fuse_in = 1'b0, brownout_level_fuse_in = 1'b0;
	logic compat_mode_fuse_in = 1'b0, watchdog_always_on_fuse_in = 1'b0;
	logic comparator_bandgap_select_in = 1'b0, adc_enable_in = 1'b0;
	logic write_in = 1'b0, read_in = 1'b0;
	logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out;
	logic [DELAY_W-1:0] startup_timeout_in = 20'h0_0014;
	logic power_on_reset_in, ext_reset_n_in, brownout_raw_in, test_reset_reg_in;
	logic watchdog_osc_in, port_reset_out, internal_reset_out, watchdog_reset_out;
	logic bandgap_enable_out, brownout_level_high_out;
	int fails = 0, compares = 0, hits = 0, n;
	logic [1:0] fz[4] = '{2'b10, 2'b01, 2'b11, 2'b00};
	logic [7:0] st[4] = '{8'h02, 8'h08, 8'h08, 8'h04};
	logic [7:0] ini[4] = '{8'h00, 8'h08, 8'h08, 8'h00};
	logic [7:0] ex2[4] = '{8'h12, 8'h1A, 8'h1A, 8'h12};
	int ss[7] = '{0, 1, 1, 2, 2, 2, 3};
	int sn[7] = '{3, 50, 200, 300, 100, 300, 3};
	logic [6:0] sf = 7'h30, se = 7'h65;
	always #5 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in) if (watchdog_reset_out === 1'b1) hits++;
	supply_model P (.clk_in(clk_sys_in), .por_out(power_on_reset_in),
		.ext_n_out(ext_reset_n_in), .bod_out(brownout_raw_in),
		.test_out(test_reset_reg_in), .osc_out(watchdog_osc_in));
	reset_control_with_watchdog #(.WDT_BASE_CYCLES(4)) DUT (.*);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		addr_in <= a;
		wdata_in <= d;
		write_in <= 1'b1;
		@(posedge clk_sys_in);
		write_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys_in);
		addr_in <= a;
		read_in <= 1'b1;
		@(posedge clk_sys_in);
		read_in <= 1'b0;
		#1 chk(rdata_out, exp);
	endtask
	// bounded, so a stuck reset shows as a counted failure
	task automatic wait_rel();
		n = 0;
		while (internal_reset_out !== 1'b0 && n < 3000) begin
			@(posedge clk_sys_in);
			#1 n++;
		end
		if (n >= 3000) begin
			fails++;
		end
	endtask
	task automatic do_reset();
		@(posedge clk_sys_in);
		rstn_in <= 1'b0;
		repeat (3) @(posedge clk_sys_in);
		rstn_in <= 1'b1;
		#1 wait_rel();
		chk(8'(n >= 20 && n <= 25), 8'h01);
	endtask
	task automatic wrap_up();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#500_000 fails++;
		wrap_up();
	end
	initial begin
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys_in);
			{compat_mode_fuse_in, watchdog_always_on_fuse_in} <= fz[i];
			do_reset();
			rd(8'h01, st[i]);
			rd(8'h00, ini[i]);
			wr(8'h00, 8'h18);
			wr(8'h00, 8'h02);
			rd(8'h00, ex2[i]);
		end
		rd(8'h7F, 8'h00);
		$display("safety levels done");
		wr(8'h00, 8'h09);
		rd(8'h00, 8'h0A);
		wr(8'h00, 8'h00);
		rd(8'h00, 8'h0A);
		n = hits;
		repeat (12) begin
			repeat (300) @(posedge clk_sys_in);
			watchdog_restart_in <= 1'b1;
			@(posedge clk_sys_in);
			watchdog_restart_in <= 1'b0;
		end
		chk(8'(hits - n), 8'h00);
		wr(8'h00, 8'h18);
		wr(8'h00, 8'h09);
		rd(8'h00, 8'h19);
		n = 0;
		while (watchdog_reset_out !== 1'b1 && n < 1200) begin
			@(posedge clk_sys_in);
			#1 n++;
		end
		chk(8'(n >= 650 && n <= 850), 8'h01);
		@(posedge clk_sys_in);
		#1 wait_rel();
		chk(8'(n >= 20 && n <= 22), 8'h01);
		rd(8'h00, 8'h00);
		$display("watchdog done");
		for (int i = 0; i < 7; i++) begin
			@(posedge clk_sys_in);
			brownout_enable_fuse_in <= sf[i];
			P.hit(ss[i], sn[i]);
			repeat (5) @(posedge clk_sys_in);
			#1 chk(8'(internal_reset_out), 8'(se[i]));
			wait_rel();
		end
		$display("reset sources done");
		for (int v = 0; v < 8; v++) begin
			@(posedge clk_sys_in);
			{brownout_enable_fuse_in, comparator_bandgap_select_in, adc_enable_in} <= 3'(v);
			brownout_level_fuse_in <= v[0];
			repeat (2) @(posedge clk_sys_in);
			#1 chk(8'(bandgap_enable_out), 8'(v != 0));
			chk(8'(brownout_level_high_out), 8'(v[0]));
		end
		$display("bandgap and level done");
		wrap_up();
	end
endmodule
